// [common/clock_front_pkg.sv]
// Purpose: Shared constants for the clock source and tick counter front end.
// Assumes: 125 MHz mclk; registers reached over classic Wishbone with 32-bit words.
// Notes: Register offsets are byte addresses on an 8-bit address.
// How it works
// RULE1 - Thirteen-bit central tick counter steps on every 1 kHz slow tick.
// RULE2 - Central counter holds still during hibernate and during debug halt.
// RULE3 - Firmware may clear the central counter to zero whenever it likes.
// RULE4 - Central counter makes periodic wake events, optionally raising an interrupt.
// RULE5 - Five-bit fast counter steps at 100 kHz, wraps at programmable terminal count.
// RULE6 - Fast counter terminal count wakes the system and optionally interrupts.
// RULE7 - Low-speed oscillator supplies 1 kHz, about 33 kHz and 100 kHz clocks.
// RULE8 - The 33 kHz clock is the 100 kHz clock divided by three.
// RULE9 - Main internal oscillator frequency selects 3, 6, 12 or 24 MHz.
// RULE10 - Multiplier reference chooses main oscillator, fast crystal or interconnect clock.
// RULE11 - Multiplier outputs 24 to 40 MHz using input and feedback divider settings.
// RULE12 - Multiplier locks within 250 us, then sets a readable lock bit.
// RULE13 - System stays on the reference clock until multiplier lock is signalled.
// RULE14 - Multiplier lock is routed out to the interconnect for interrupt use.
// RULE15 - Firmware turns the multiplier off before any low-power mode.
// RULE16 - Doubler turns a 24 MHz input into the 48 MHz serial bus clock.
// RULE17 - Doubler input chooses main oscillator, fast crystal or interconnect clock.
// RULE18 - Eight digital, four analog and one bus clock divider, all 16-bit.
// RULE19 - Up to eight extra interconnect clocks feed the eight digital dividers.
// RULE20 - Watch crystal drives a once-per-second interrupt for firmware timekeeping.
// RULE21 - Watch crystal has two selectable power modes.
// RULE22 - Tick counter interrupt flags stay set until software clears them.
// RULE23 - Each divider picks one of eight inputs and divides by two or more.
package clock_front_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int LOCK_TIME_NS = 250000;
    localparam int LOCK_CYCLES = LOCK_TIME_NS / CLK_PERIOD_NS;
    localparam int WATCH_TICKS = 32768;
    localparam int CTW_W = 13;
    localparam int FAST_W = 5;
    localparam int DIV_W = 16;
    localparam int NUM_DIG_DIV = 8;
    localparam int NUM_DIV = 13;
    localparam int DIV_SEL_W = 3;
    localparam logic [1:0] THIRD_LAST = 2'h2;
    localparam logic [7:0] ADR_TICK_CTRL = 8'h00;
    localparam logic [7:0] ADR_TICK_STAT = 8'h04;
    localparam logic [7:0] ADR_OSC_CTRL = 8'h08;
    localparam logic [7:0] ADR_PLL_DIV = 8'h0C;
    localparam logic [7:0] ADR_OSC_STAT = 8'h10;
    localparam logic [7:0] ADR_DIV_BASE = 8'h20;
    localparam logic [7:0] ADR_DIV_END = 8'h54;
    localparam int F_CTW_TAP = 0;
    localparam int F_CTW_IRQ_EN = 4;
    localparam int F_FAST_IRQ_EN = 5;
    localparam int F_SEC_IRQ_EN = 6;
    localparam int F_FAST_TC = 8;
    localparam int F_CTW_CLEAR = 16;
    localparam int F_CTW_FLAG = 24;
    localparam int F_FAST_FLAG = 25;
    localparam int F_SEC_FLAG = 26;
    localparam int F_IMO_FREQ = 0;
    localparam int F_PLL_SRC = 2;
    localparam int F_PLL_EN = 4;
    localparam int F_DBL_SRC = 5;
    localparam int F_DBL_EN = 7;
    localparam int F_SYS_PLL = 8;
    localparam int F_WATCH_PWR = 9;
    localparam int F_PLL_IN = 0;
    localparam int F_PLL_FB = 8;
    localparam int F_DIV_SRC = 16;
    localparam logic [3:0] RST_CTW_TAP = 4'hA;
    localparam logic [4:0] RST_FAST_TC = 5'h1F;
    localparam logic [15:0] RST_DIV = 16'h0002;
    localparam logic [5:0] RST_PLL_IN = 6'h00;
    localparam logic [5:0] RST_PLL_FB = 6'h07;
    typedef enum logic [1:0] {
        IMO_3MHZ = 2'h0, IMO_6MHZ = 2'h1, IMO_12MHZ = 2'h2, IMO_24MHZ = 2'h3
    } imo_freq_t;
    typedef enum logic [1:0] {
        REF_MAIN_OSC = 2'h0, REF_FAST_XTAL = 2'h1, REF_INTERCONNECT = 2'h2
    } ref_src_t;
    typedef enum logic [1:0] {
        PLL_OFF = 2'b00, PLL_WAIT = 2'b01, PLL_LOCKED = 2'b11
    } pll_state_t;
endpackage

// [core/clock_source_and_timewheels.sv]
// Purpose: Clock source selection, multiplier lock timing, tick counters and dividers.
// Assumes: Oscillator outputs arrive as asynchronous levels; divider sources as mclk ticks.
// Notes: Analog oscillators, multiplier and doubler live outside; this block steers them.
`timescale 1ns/10ps
`default_nettype none
module clock_source_and_timewheels #(
    parameter int LOCK_COUNT = clock_front_pkg::LOCK_CYCLES,
    parameter int WATCH_COUNT = clock_front_pkg::WATCH_TICKS
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic slow_tick_clock,
    input wire logic fast_tick_clock,
    input wire logic watch_crystal_osc,
    input wire logic hibernate,
    input wire logic debug_halt,
    input wire logic [6:0] src_tick,
    input wire logic [7:0] interconnect_tick,
    output logic third_rate_clock,
    output logic ctw_wake,
    output logic fast_wake,
    output logic ctw_irq,
    output logic fast_irq,
    output logic second_irq,
    output clock_front_pkg::imo_freq_t imo_freq_sel,
    output clock_front_pkg::ref_src_t pll_ref_sel,
    output logic pll_enable,
    output logic [5:0] pll_in_div,
    output logic [5:0] pll_fb_div,
    output logic pll_lock_route,
    output clock_front_pkg::ref_src_t doubler_ref_sel,
    output logic doubler_enable,
    output logic sys_clk_on_pll,
    output logic watch_power_mode,
    output logic [12:0] div_clk
);
    import clock_front_pkg::*;

    localparam int LW = $clog2(LOCK_COUNT + 1);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        merge = (old & ~m) | (nw & m);
    endfunction

    // Oscillator levels cross in through three flops; a level counts once flops two and
    // three agree, which rejects a single metastable sample.
    logic [2:0] s1, s2, s3, lvl;
    wire [2:0] async_in = {watch_crystal_osc, fast_tick_clock, slow_tick_clock};
    wire [2:0] agree = ~(s2 ^ s3);
    wire [2:0] next_lvl = (agree & s3) | (~agree & lvl);
    wire [2:0] rise = next_lvl & ~lvl;
    wire tick_1k = rise[0];
    wire tick_100k = rise[1];
    wire tick_32k = rise[2];

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s1 <= 3'h0;
            s2 <= 3'h0;
            s3 <= 3'h0;
            lvl <= 3'h0;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            lvl <= next_lvl; // RULE7
        end
    end

    // Software visible state, plus the unreadable sec_cnt, cnt3 and lock_cnt counters.
    logic [3:0] ctw_tap;
    logic ctw_irq_en, fast_irq_en, sec_irq_en;
    logic [4:0] fast_tc;
    logic sys_pll_req;
    logic [DIV_W-1:0] div_val [NUM_DIV];
    logic [DIV_SEL_W-1:0] div_src [NUM_DIV];
    logic [CTW_W-1:0] ctw_cnt;
    logic [FAST_W-1:0] fast_cnt;
    logic [15:0] sec_cnt;
    logic ctw_flag, fast_flag, sec_flag;
    logic [1:0] cnt3;
    pll_state_t pll_state;
    logic [LW-1:0] lock_cnt;
    wire pll_locked = (pll_state == PLL_LOCKED);

    // Bus decode.
    wire req = cyc_i & stb_i & ~ack_o;
    wire wr = req & we_i;
    wire hit_tick_ctrl = (adr_i == ADR_TICK_CTRL);
    wire hit_tick_stat = (adr_i == ADR_TICK_STAT);
    wire hit_osc_ctrl = (adr_i == ADR_OSC_CTRL);
    wire hit_pll_div = (adr_i == ADR_PLL_DIV);
    wire hit_osc_stat = (adr_i == ADR_OSC_STAT);
    wire hit_div = (adr_i >= ADR_DIV_BASE) && (adr_i < ADR_DIV_END) && (adr_i[1:0] == 2'h0);
    wire [7:0] div_off = adr_i - ADR_DIV_BASE;
    wire [3:0] div_idx = div_off[5:2];

    wire [31:0] tick_ctrl_img = {15'h0, 1'b0, 3'h0, fast_tc, 1'b0, sec_irq_en, fast_irq_en,
                                 ctw_irq_en, ctw_tap};
    wire [31:0] tick_stat_img = {5'h0, sec_flag, fast_flag, ctw_flag, 3'h0, fast_cnt, 3'h0,
                                 ctw_cnt};
    wire [31:0] osc_ctrl_img = {22'h0, watch_power_mode, sys_pll_req, doubler_enable,
                                doubler_ref_sel, pll_enable, pll_ref_sel, imo_freq_sel};
    wire [31:0] pll_div_img = {18'h0, pll_fb_div, 2'h0, pll_in_div};
    wire [31:0] osc_stat_img = {30'h0, sys_clk_on_pll, pll_locked};
    wire [31:0] div_img = hit_div ? {13'h0, div_src[div_idx], div_val[div_idx]} : 32'h0;

    wire [31:0] rd_data = hit_tick_ctrl ? tick_ctrl_img :
                          hit_tick_stat ? tick_stat_img :
                          hit_osc_ctrl ? osc_ctrl_img :
                          hit_pll_div ? pll_div_img :
                          hit_osc_stat ? osc_stat_img :
                          div_img;
    wire [31:0] wd = merge(rd_data, dat_i, sel_i);
    wire [31:0] flag_clr = (wr & hit_tick_stat) ? merge(32'h0, dat_i, sel_i) : 32'h0;
    wire ctw_clear = wr & hit_tick_ctrl & wd[F_CTW_CLEAR];
    wire pll_cfg_wr = wr & (hit_pll_div |
                      (hit_osc_ctrl & (wd[F_PLL_SRC +: 2] != pll_ref_sel)));

    // Unmapped addresses still answer, reading zero and ignoring writes.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= req;
            dat_o <= req ? rd_data : 32'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctw_tap <= RST_CTW_TAP;
            ctw_irq_en <= 1'b0;
            fast_irq_en <= 1'b0;
            sec_irq_en <= 1'b0;
            fast_tc <= RST_FAST_TC;
        end else if (wr && hit_tick_ctrl) begin
            ctw_tap <= wd[F_CTW_TAP +: 4];
            ctw_irq_en <= wd[F_CTW_IRQ_EN]; // RULE4
            fast_irq_en <= wd[F_FAST_IRQ_EN]; // RULE6
            sec_irq_en <= wd[F_SEC_IRQ_EN];
            fast_tc <= wd[F_FAST_TC +: FAST_W]; // RULE5
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            imo_freq_sel <= IMO_3MHZ;
            pll_ref_sel <= REF_MAIN_OSC;
            pll_enable <= 1'b0;
            doubler_ref_sel <= REF_MAIN_OSC;
            doubler_enable <= 1'b0;
            sys_pll_req <= 1'b0;
            watch_power_mode <= 1'b0;
        end else if (wr && hit_osc_ctrl) begin
            imo_freq_sel <= imo_freq_t'(wd[F_IMO_FREQ +: 2]); // RULE9
            pll_ref_sel <= ref_src_t'(wd[F_PLL_SRC +: 2]); // RULE10
            pll_enable <= wd[F_PLL_EN];
            doubler_ref_sel <= ref_src_t'(wd[F_DBL_SRC +: 2]); // RULE17
            doubler_enable <= wd[F_DBL_EN]; // RULE16
            sys_pll_req <= wd[F_SYS_PLL];
            watch_power_mode <= wd[F_WATCH_PWR]; // RULE21
        end
    end

    // Six-bit input and feedback dividers give the multiplier its ratio range.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pll_in_div <= RST_PLL_IN;
            pll_fb_div <= RST_PLL_FB;
        end else if (wr && hit_pll_div) begin
            pll_in_div <= wd[F_PLL_IN +: 6]; // RULE11
            pll_fb_div <= wd[F_PLL_FB +: 6]; // RULE11
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int k = 0; k < NUM_DIV; k++) begin
                div_val[k] <= RST_DIV;
                div_src[k] <= 3'h0;
            end
        end else if (wr && hit_div) begin
            div_val[div_idx] <= wd[DIV_W-1:0];
            div_src[div_idx] <= wd[F_DIV_SRC +: DIV_SEL_W]; // RULE23
        end
    end

    // Central tick counter.
    wire ctw_run = ~hibernate & ~debug_halt;
    wire [CTW_W-1:0] ctw_next = ctw_cnt + 13'h0001;
    logic [CTW_W-1:0] tap_mask;
    always_comb begin
        for (int k = 0; k < CTW_W; k++) begin
            tap_mask[k] = (k <= int'(ctw_tap));
        end
    end
    wire ctw_step = tick_1k & ctw_run & ~ctw_clear;
    wire ctw_event = ctw_step & ((ctw_next & tap_mask) == 13'h0000);
    wire fast_event = tick_100k & ctw_run & (fast_cnt == fast_tc);
    wire sec_event = tick_32k & (sec_cnt == 16'(WATCH_COUNT - 1));

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctw_cnt <= 13'h0000;
        end else if (ctw_clear) begin
            ctw_cnt <= 13'h0000; // RULE3
        end else if (ctw_step) begin
            ctw_cnt <= ctw_next; // RULE1 RULE2
        end
    end

    // The fast counter also stops in hibernate and in debug halt, gated by the same ctw_run.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fast_cnt <= 5'h00;
        end else if (fast_event) begin
            fast_cnt <= 5'h00; // RULE5
        end else if (tick_100k && ctw_run) begin
            fast_cnt <= fast_cnt + 5'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sec_cnt <= 16'h0000;
        end else if (sec_event) begin
            sec_cnt <= 16'h0000; // RULE20
        end else if (tick_32k) begin
            sec_cnt <= sec_cnt + 16'h0001;
        end
    end

    // A new event wins over a clear landing in the same cycle.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctw_flag <= 1'b0;
            fast_flag <= 1'b0;
            sec_flag <= 1'b0;
            ctw_wake <= 1'b0;
            fast_wake <= 1'b0;
            ctw_irq <= 1'b0;
            fast_irq <= 1'b0;
            second_irq <= 1'b0;
        end else begin
            ctw_flag <= (ctw_flag & ~flag_clr[F_CTW_FLAG]) | ctw_event; // RULE22
            fast_flag <= (fast_flag & ~flag_clr[F_FAST_FLAG]) | fast_event; // RULE22
            sec_flag <= (sec_flag & ~flag_clr[F_SEC_FLAG]) | sec_event; // RULE20
            ctw_wake <= ctw_event; // RULE4
            fast_wake <= fast_event; // RULE6
            ctw_irq <= ctw_irq_en & ((ctw_flag & ~flag_clr[F_CTW_FLAG]) | ctw_event); // RULE4
            fast_irq <= fast_irq_en & ((fast_flag & ~flag_clr[F_FAST_FLAG]) | fast_event);
            second_irq <= sec_irq_en & ((sec_flag & ~flag_clr[F_SEC_FLAG]) | sec_event);
        end
    end

    // Divide-by-three of the 100 kHz tick; high for one of every three input periods.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt3 <= 2'h0;
            third_rate_clock <= 1'b0;
        end else if (tick_100k) begin
            cnt3 <= (cnt3 == THIRD_LAST) ? 2'h0 : cnt3 + 2'h1; // RULE8
            third_rate_clock <= (cnt3 == THIRD_LAST); // RULE8
        end
    end

    // Lock timer; any change of reference or ratio restarts it, since the loop relocks.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pll_state <= PLL_OFF;
            lock_cnt <= '0;
        end else begin
            case (pll_state)
                PLL_OFF: begin
                    lock_cnt <= '0;
                    if (pll_enable) begin
                        pll_state <= PLL_WAIT;
                    end
                end
                PLL_WAIT: begin
                    if (!pll_enable) begin
                        pll_state <= PLL_OFF;
                        lock_cnt <= '0;
                    end else if (pll_cfg_wr) begin
                        lock_cnt <= '0;
                    end else if (lock_cnt == LW'(LOCK_COUNT - 1)) begin
                        pll_state <= PLL_LOCKED; // RULE12
                    end else begin
                        lock_cnt <= lock_cnt + 1'b1;
                    end
                end
                PLL_LOCKED: begin
                    lock_cnt <= '0;
                    if (!pll_enable) begin
                        pll_state <= PLL_OFF;
                    end else if (pll_cfg_wr) begin
                        pll_state <= PLL_WAIT;
                    end
                end
                default: begin
                    pll_state <= PLL_OFF;
                    lock_cnt <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pll_lock_route <= 1'b0;
            sys_clk_on_pll <= 1'b0;
        end else begin
            pll_lock_route <= pll_locked; // RULE14
            sys_clk_on_pll <= sys_pll_req & pll_locked; // RULE13
        end
    end

    // Dividers 0-7 digital, 8-11 analog, 12 the processor bus.
    for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
        logic [DIV_W-1:0] dcnt;
        wire [7:0] srcs;
        if (i < NUM_DIG_DIV) begin : g_dig
            assign srcs = {interconnect_tick[i], src_tick}; // RULE19
        end else begin : g_other
            assign srcs = {1'b0, src_tick};
        end
        wire [DIV_W-1:0] eff = (div_val[i] < 16'h0002) ? 16'h0002 : div_val[i];
        wire [DIV_W-1:0] dnext = (dcnt >= eff - 16'h0001) ? 16'h0000 : dcnt + 16'h0001;
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                dcnt <= 16'h0000;
                div_clk[i] <= 1'b0;
            end else if (srcs[div_src[i]]) begin
                dcnt <= dnext; // RULE18 RULE23
                div_clk[i] <= (dnext < (eff >> 1)); // RULE23
            end
        end
    end

    // Checks.
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_clear_req;
        ctw_clear;
    endsequence
    sequence s_counter_zero;
        ctw_cnt == 13'h0000;
    endsequence

    a_ctw_clear_zero: assert property (s_clear_req |=> s_counter_zero) // RULE3
        else $error("central counter not cleared");
    a_ctw_step_one: assert property (ctw_step |=> ctw_cnt == $past(ctw_cnt) + 13'h0001) // RULE1
        else $error("central counter did not step by one");
    a_ctw_halt_hold: assert property ((hibernate || debug_halt) && !ctw_clear |=> $stable(ctw_cnt)) // RULE2
        else $error("central counter moved while halted");
    a_fast_wrap_zero: assert property (fast_event |=> fast_cnt == 5'h00 ##0 fast_wake) // RULE5
        else $error("fast counter did not wrap");
    a_fast_irq_gate: assert property (fast_event && fast_irq_en |=> fast_irq) // RULE6
        else $error("fast interrupt missing");
    a_flag_sticky: assert property (ctw_flag && !flag_clr[F_CTW_FLAG] |=> ctw_flag) // RULE22
        else $error("central flag lost without a clear");
    a_third_period: assert property ($rose(third_rate_clock) |-> $past(cnt3) == THIRD_LAST) // RULE8
        else $error("third rate clock out of step");
    a_lock_after_wait: assert property ($rose(pll_locked) |-> $past(lock_cnt) == LW'(LOCK_COUNT - 1)) // RULE12
        else $error("lock set before lock time");
    a_sys_needs_lock: assert property (sys_clk_on_pll |-> $past(pll_locked)) // RULE13
        else $error("system on multiplier before lock");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// [tb/tb_clock_source_and_timewheels.sv]
// Purpose: Self-checking bench for the clock source and tick counter block.
// Assumes: The slave answers each Wishbone cycle in its own time; oscillators are slow levels.
// Notes: Short lock and watch counts keep the run brief; expectations follow those values.
`timescale 1ns/10ps
`default_nettype none
module tb_clock_source_and_timewheels import clock_front_pkg::*;;
    localparam int LK = 20;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h00000000;
    logic [2:0] osc = 3'h0;
    logic hib = 1'b0;
    logic dbg = 1'b0;
    logic [6:0] src = 7'h00;
    logic [7:0] itk = 8'h00;
    logic [31:0] dat_o;
    logic [31:0] q;
    logic [31:0] v;
    logic ack_o, third, ctw_wake, fast_wake, ctw_irq, fast_irq, second_irq;
    logic pll_en, lock, on_pll, wpm, dbl_en, third_q, div_q;
    imo_freq_t main_internal_osc;
    ref_src_t pref, dref;
    logic [5:0] pin, pfb;
    logic [12:0] div_clk;
    int error_cnt = 0;
    int compares = 0;
    int n_ctw = 0;
    int n_fast = 0;
    int n_third = 0;
    int n_div = 0;

    clock_source_and_timewheels #(.LOCK_COUNT(LK), .WATCH_COUNT(8)) dut_u (
        .mclk(mclk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .slow_tick_clock(osc[0]), .fast_tick_clock(osc[1]), .watch_crystal_osc(osc[2]),
        .hibernate(hib), .debug_halt(dbg), .src_tick(src), .interconnect_tick(itk),
        .third_rate_clock(third), .ctw_wake(ctw_wake), .fast_wake(fast_wake),
        .ctw_irq(ctw_irq), .fast_irq(fast_irq), .second_irq(second_irq),
        .imo_freq_sel(main_internal_osc), .pll_ref_sel(pref), .pll_enable(pll_en), .pll_in_div(pin),
        .pll_fb_div(pfb), .pll_lock_route(lock), .doubler_ref_sel(dref),
        .doubler_enable(dbl_en), .sys_clk_on_pll(on_pll), .watch_power_mode(wpm),
        .div_clk(div_clk));

    always #4 mclk = ~mclk;

    // Event pulses are counted here so that no single-cycle pulse slips past a test.
    always @(posedge mclk) begin
        third_q <= third;
        div_q <= div_clk[0];
        if (ctw_wake === 1'b1) n_ctw <= n_ctw + 1;
        if (fast_wake === 1'b1) n_fast <= n_fast + 1;
        if (third === 1'b1 && third_q === 1'b0) n_third <= n_third + 1;
        if (div_clk[0] === 1'b1 && div_q === 1'b0) n_div <= n_div + 1;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack_o !== 1'b1 && n < 40);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 40) chk("bus ack", 32'h00000001, 32'h00000000);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h00000000);
        chk($sformatf("read of %h", a), e, q);
    endtask

    // Each oscillator period is long enough for the three-stage synchroniser to settle.
    task automatic tick(input int k, input int n);
        repeat (n) begin
            @(posedge mclk);
            osc[k] <= 1'b1;
            repeat (6) @(posedge mclk);
            osc[k] <= 1'b0;
            repeat (6) @(posedge mclk);
        end
    endtask

    task automatic settle();
        repeat (2) @(negedge mclk);
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        results();
    end

    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rd(ADR_TICK_CTRL, 32'h00001F0A);
        rd(ADR_PLL_DIV, 32'h00000700);
        rd(ADR_DIV_BASE, 32'h00000002);
        rd(8'h50, 32'h00000002);
        wr(8'h18, 32'hFFFFFFFF);
        rd(8'h18, 32'h00000000);
        $display("test reset and map done");
        wr(ADR_TICK_CTRL, 32'h00000270);
        tick(0, 5);
        rd(ADR_TICK_STAT, 32'h01000005);
        chk("central wakes", 32'h2, n_ctw);
        chk("central irq", 32'h1, {31'h0, ctw_irq});
        wr(ADR_TICK_STAT, 32'h01000000);
        settle();
        chk("central irq cleared", 32'h0, {31'h0, ctw_irq});
        $display("test central counter done");
        tick(1, 1);
        n_fast = 0;
        n_third = 0;
        tick(1, 6);
        chk("fast wakes", 32'h2, n_fast);
        chk("third rate rises", 32'h2, n_third);
        rd(ADR_TICK_STAT, 32'h02010005);
        chk("fast irq", 32'h1, {31'h0, fast_irq});
        $display("test fast counter done");
        for (int m = 0; m < 2; m++) begin
            hib <= (m == 0);
            dbg <= (m == 1);
            tick(0, 2);
            tick(1, 2);
            rd(ADR_TICK_STAT, 32'h02010005);
        end
        hib <= 1'b0;
        dbg <= 1'b0;
        wr(ADR_TICK_CTRL, 32'h00010270);
        rd(ADR_TICK_STAT, 32'h02010000);
        wr(ADR_TICK_STAT, 32'h02000000);
        rd(ADR_TICK_STAT, 32'h00010000);
        tick(2, 8);
        rd(ADR_TICK_STAT, 32'h04010000);
        chk("second irq", 32'h1, {31'h0, second_irq});
        $display("test halt, clear and second done");
        for (int i = 0; i < 4; i++) begin
            v = 32'(i) | (32'(i % 3) << 2) | (32'(i % 3) << 5);
            wr(ADR_OSC_CTRL, v);
            settle();
            chk("main osc select", 32'(i), {30'h0, main_internal_osc});
            chk("multiplier ref", 32'(i % 3), {30'h0, pref});
            chk("doubler ref", 32'(i % 3), {30'h0, dref});
        end
        wr(ADR_PLL_DIV, 32'h00000305);
        rd(ADR_PLL_DIV, 32'h00000305);
        chk("multiplier dividers", 32'h00000305, {18'h0, pfb, 2'h0, pin});
        wr(ADR_OSC_CTRL, 32'h000003D6);
        rd(ADR_OSC_STAT, 32'h00000000);
        repeat (LK + 10) @(posedge mclk);
        rd(ADR_OSC_STAT, 32'h00000003);
        chk("lock route", 32'h1, {31'h0, lock});
        chk("doubler and watch", 32'h7, {29'h0, dbl_en, wpm, pll_en});
        chk("system on multiplier", 32'h1, {31'h0, on_pll});
        wr(ADR_OSC_CTRL, 32'h000003C6);
        rd(ADR_OSC_STAT, 32'h00000000);
        $display("test oscillator control done");
        wr(ADR_DIV_BASE, 32'h00000004);
        rd(ADR_DIV_BASE, 32'h00000004);
        for (int p = 0; p < 10; p++) begin
            if (p == 2) n_div = 0;
            @(posedge mclk);
            src[0] <= 1'b1;
            @(posedge mclk);
            src[0] <= 1'b0;
            @(posedge mclk);
        end
        settle();
        chk("divider rises", 32'h2, n_div);
        wr(ADR_DIV_BASE, 32'h00070002);
        n_div = 0;
        for (int p = 0; p < 4; p++) begin
            @(posedge mclk);
            itk[0] <= 1'b1;
            @(posedge mclk);
            itk[0] <= 1'b0;
            @(posedge mclk);
        end
        settle();
        chk("interconnect divider rises", 32'h2, n_div);
        $display("test divider done");
        results();
    end
endmodule
`default_nettype wire
